//--- eas_defs.vh
// constants for the energy accumulate and sign detect block
// assumes inclusion by the datapath files only
`ifndef EAS_DEFS_VH
`define EAS_DEFS_VH
`define EAS_CLK_HZ 100000000
`define EAS_LPF_CORNER_HZ 8
`define EAS_PHASE_COMP_MAX_HZ 1000
// lpf shift k: pole 1-2^-k at sample rate; 2^k chosen near fs/(2*pi*8)
`define EAS_LPF_SHIFT 20
`define EAS_HPF_SHIFT 16
`define EAS_CF_RATIO 160
`define EAS_SLOW_THRESH 48'h0000_A000_0000
`define EAS_PULSE_US 1
`define EAS_PULSE_CYC ((`EAS_PULSE_US * (`EAS_CLK_HZ / 1000000)))
`define EAS_NOLOAD_DEF 32'h0000_0100
`endif

//--- eas_phase_chan.v
// one phase: current hpf, phase compensation, multiply, product lpf
// assumes signed samples with a one-cycle valid strobe on mclk
`timescale 1ns/1ps
`include "eas_defs.vh"
module eas_phase_chan #(
  parameter SW = 16,
  parameter HPF_K = `EAS_HPF_SHIFT,
  parameter LPF_K = `EAS_LPF_SHIFT
) (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // samples
  input wire sample_valid,
  input wire signed [SW-1:0] volt_in,
  input wire signed [SW-1:0] curr_in,
  // filtered power
  output reg signed [2*SW-1:0] power_reg
);
  localparam PW = 2 * SW;
  localparam HW = SW + HPF_K;
  localparam LW = PW + LPF_K;
  reg signed [HW-1:0] hpf_acc_reg;
  reg signed [SW-1:0] volt_d_reg;
  reg signed [SW-1:0] volt_comp_reg;
  reg signed [SW-1:0] curr_hp_reg;
  reg signed [LW-1:0] lpf_acc_reg;
  wire signed [SW-1:0] dc_est;
  wire signed [SW:0] curr_hp_w;
  wire signed [SW:0] volt_sum;
  wire signed [PW-1:0] prod;
  wire signed [LW-1:0] lpf_next;
  // dc estimate tracks the offset; subtracting it removes dc
  assign dc_est = hpf_acc_reg[HW-1:HPF_K];
  assign curr_hp_w = {curr_in[SW-1], curr_in} - {dc_est[SW-1], dc_est};
  // first-order hpf leads by about half a sample at low f; averaging
  // two voltage samples delays voltage by the same half sample
  assign volt_sum = {volt_in[SW-1], volt_in} + {volt_d_reg[SW-1], volt_d_reg};
  assign prod = curr_hp_reg * volt_comp_reg;
  // the cast keeps the whole sum signed, so the leak shift stays arithmetic
  assign lpf_next = lpf_acc_reg + $signed({{LPF_K{prod[PW-1]}}, prod})
    - (lpf_acc_reg >>> LPF_K);
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hpf_acc_reg <= {HW{1'b0}};
      volt_d_reg <= {SW{1'b0}};
      volt_comp_reg <= {SW{1'b0}};
      curr_hp_reg <= {SW{1'b0}};
      lpf_acc_reg <= {LW{1'b0}};
      power_reg <= {PW{1'b0}};
    end else if (sample_valid) begin
      hpf_acc_reg <= hpf_acc_reg + {{(HPF_K-1){curr_hp_w[SW]}}, curr_hp_w}; // R1
      curr_hp_reg <= curr_hp_w[SW-1:0]; // R1
      volt_d_reg <= volt_in;
      volt_comp_reg <= volt_sum[SW:1]; // R2
      lpf_acc_reg <= lpf_next; // R3 R4
      power_reg <= lpf_next[LW-1:LPF_K]; // R3
    end
  end
endmodule // eas_phase_chan

//--- eas_top.v
// three-phase energy accumulate, pulse outputs and negative-total flag
// assumes synchronous sample strobes; sys_rst driven by supply monitor
`timescale 1ns/1ps
`include "eas_defs.vh"
// Behaviour
// R1 - high-pass filter current removes offset
// R2 - compensate hpf phase up to 1 kHz
// R3 - low-pass filter each phase product
// R4 - single-pole lpf corner at 8 Hz
// R5 - accumulate power, pulse from accumulation
// R6 - slow outputs proportional to average power
// R7 - calibration output up to 160x faster
// R8 - host averages calibration pulse rate
// R9 - host picks long enough integration period
// R10 - select high arithmetic, low absolute sum
// R11 - absolute mode counts every phase positive
// R12 - sign detect on arithmetic sum always
// R13 - flag high negative, low positive
// R14 - flag updates only on calibration pulse
// R15 - flag holds until positive or no-load
// R16 - slow outputs are active-high pulses
// R17 - supply fault resets datapath, no pulses
// R18 - pulse on threshold, subtract, keep remainder
// R19 - everything synchronous to master clock
module eas_top #(
  parameter SW = 16,
  parameter SLOW_THRESH = `EAS_SLOW_THRESH,
  parameter CF_RATIO = `EAS_CF_RATIO,
  parameter PULSE_CYC = `EAS_PULSE_CYC,
  parameter NOLOAD = `EAS_NOLOAD_DEF
) (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // samples
  input wire sample_valid,
  input wire [SW-1:0] volt_a,
  input wire [SW-1:0] curr_a,
  input wire [SW-1:0] volt_b,
  input wire [SW-1:0] curr_b,
  input wire [SW-1:0] volt_c,
  input wire [SW-1:0] curr_c,
  // mode
  input wire magnitude_sum_select_n,
  // outputs
  output reg slow_pulse_out_1,
  output reg slow_pulse_out_2,
  output reg calibration_pulse_out,
  output reg negative_total_power_flag
);
  localparam PW = 2 * SW;
  localparam AW = 48;
  localparam CW = 16;
  localparam [AW-1:0] SLOW_T = SLOW_THRESH;
  // cf threshold rounds down, so its rate sits a hair above CF_RATIO
  localparam [AW-1:0] CF_T = SLOW_THRESH / CF_RATIO;
  localparam [CW-1:0] PULSE_N = PULSE_CYC[CW-1:0];
  localparam [PW-1:0] NOLOAD_T = NOLOAD;
  // slow output states, one-hot
  localparam ST_IDLE = 3'b001;
  localparam ST_P1 = 3'b010;
  localparam ST_P2 = 3'b100;

  wire signed [PW-1:0] pw_a;
  wire signed [PW-1:0] pw_b;
  wire signed [PW-1:0] pw_c;
  reg signed [AW-1:0] slow_acc_reg;
  reg signed [AW-1:0] cf_acc_reg;
  reg [CW-1:0] slow_cnt_reg;
  reg [CW-1:0] cf_cnt_reg;
  reg [2:0] state_reg;
  reg upd_reg;

  function [AW-1:0] sext;
    input [PW-1:0] v;
    begin
      sext = {{(AW-PW){v[PW-1]}}, v};
    end
  endfunction

  function [AW-1:0] magn;
    input [PW-1:0] v;
    begin
      magn = v[PW-1] ? sext(~v + 1'b1) : sext(v);
    end
  endfunction

  function below;
    input [PW-1:0] v;
    begin
      below = (magn(v) < sext(NOLOAD_T));
    end
  endfunction

  // reverse energy pulses too, so the flag can follow a negative total
  function crossed;
    input [AW-1:0] s;
    input [AW-1:0] t;
    begin
      crossed = ($signed(s) >= $signed(t)) || ($signed(s) <= -$signed(t));
    end
  endfunction

  // take one threshold off the side that was crossed, keep the rest
  function [AW-1:0] settle;
    input [AW-1:0] s;
    input [AW-1:0] t;
    begin
      settle = s[AW-1] ? s + t : s - t;
    end
  endfunction

  // width counter steps down to zero and rests there
  function [CW-1:0] tick;
    input [CW-1:0] c;
    begin
      tick = (c > 16'h0001) ? c - 16'h0001 : {CW{1'b0}};
    end
  endfunction

  eas_phase_chan #(.SW(SW)) u_pa (
    .mclk(mclk), .sys_rst(sys_rst), .sample_valid(sample_valid),
    .volt_in(volt_a), .curr_in(curr_a), .power_reg(pw_a));
  eas_phase_chan #(.SW(SW)) u_pb (
    .mclk(mclk), .sys_rst(sys_rst), .sample_valid(sample_valid),
    .volt_in(volt_b), .curr_in(curr_b), .power_reg(pw_b));
  eas_phase_chan #(.SW(SW)) u_pc (
    .mclk(mclk), .sys_rst(sys_rst), .sample_valid(sample_valid),
    .volt_in(volt_c), .curr_in(curr_c), .power_reg(pw_c));

  wire [AW-1:0] arith_sum = sext(pw_a) + sext(pw_b) + sext(pw_c); // R12
  wire [AW-1:0] abs_sum = magn(pw_a) + magn(pw_b) + magn(pw_c); // R11
  // select high picks the signed total
  wire [AW-1:0] tot = magnitude_sum_select_n ? arith_sum : abs_sum; // R10
  // no-load test looks at each phase magnitude, sign ignored
  wire all_noload = below(pw_a) & below(pw_b) & below(pw_c);
  wire [AW-1:0] slow_sum = slow_acc_reg + tot;
  wire [AW-1:0] cf_sum = cf_acc_reg + tot;
  // crossing is signed and two-sided: reverse totals fire pulses as well
  wire slow_hit = sample_valid && crossed(slow_sum, SLOW_T);
  wire cf_hit = sample_valid && crossed(cf_sum, CF_T);

  // accumulators: cf uses a threshold CF_RATIO smaller
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      slow_acc_reg <= {AW{1'b0}}; // R17
      cf_acc_reg <= {AW{1'b0}};
    end else if (sample_valid) begin
      slow_acc_reg <= slow_hit ? settle(slow_sum, SLOW_T) // R5 R18 R6
        : slow_sum;
      cf_acc_reg <= cf_hit ? settle(cf_sum, CF_T) : cf_sum; // R7 R18
    end
  end

  // calibration pulse; a crossing inside a pulse restarts its width
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      calibration_pulse_out <= 1'b0; // R17
      cf_cnt_reg <= {CW{1'b0}};
    end else begin
      if (cf_hit) begin
        calibration_pulse_out <= 1'b1; // R19
        cf_cnt_reg <= PULSE_N;
      end else if (cf_cnt_reg > 16'h0001) begin
        cf_cnt_reg <= tick(cf_cnt_reg);
      end else begin
        cf_cnt_reg <= {CW{1'b0}};
        calibration_pulse_out <= 1'b0;
      end
    end
  end

  // negative-total flag: no-load clear wins over a pulse-time update
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      negative_total_power_flag <= 1'b0; // R17
    end else if (all_noload) begin
      negative_total_power_flag <= 1'b0; // R15
    end else if (cf_hit) begin
      negative_total_power_flag <= arith_sum[AW-1]; // R13 R14
    end
  end

  // slow pulses alternate between the two outputs, suiting a stepper;
  // a crossing during a running pulse is still settled from the accumulator but gives no pulse
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      slow_cnt_reg <= {CW{1'b0}};
      slow_pulse_out_1 <= 1'b0; // R17
      slow_pulse_out_2 <= 1'b0;
      upd_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (slow_hit) begin
            slow_cnt_reg <= PULSE_N;
            upd_reg <= ~upd_reg;
            if (upd_reg) begin
              state_reg <= ST_P2;
              slow_pulse_out_2 <= 1'b1; // R16
            end else begin
              state_reg <= ST_P1;
              slow_pulse_out_1 <= 1'b1; // R16
            end
          end
        end
        ST_P1, ST_P2: begin
          if (slow_cnt_reg > 16'h0001) begin
            slow_cnt_reg <= tick(slow_cnt_reg);
          end else begin
            slow_cnt_reg <= {CW{1'b0}};
            slow_pulse_out_1 <= 1'b0;
            slow_pulse_out_2 <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // eas_top

//--- eas_top_chk.sv
// port checker for eas_top pulse outputs and negative-total flag
// assumes a sim build with PULSE_CYC of 2 and sys_rst async high
`timescale 1ns/1ps
module eas_chk (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // watched ports
  input wire sample_valid,
  input wire slow_pulse_out_1,
  input wire slow_pulse_out_2,
  input wire calibration_pulse_out,
  input wire negative_total_power_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_cal_width: assert property ($rose(calibration_pulse_out) |-> ##1 calibration_pulse_out)
    else $error("calibration pulse too short");
  a_slow1_width: assert property ($rose(slow_pulse_out_1) |-> ##1 slow_pulse_out_1)
    else $error("slow pulse 1 too short");
  a_slow2_width: assert property ($rose(slow_pulse_out_2) |-> ##1 slow_pulse_out_2)
    else $error("slow pulse 2 too short");
  a_flag_on_cal: assert property ($rose(negative_total_power_flag) |-> calibration_pulse_out)
    else $error("flag rose without calibration pulse");
  a_cal_cause: assert property ($rose(calibration_pulse_out) |-> $past(sample_valid))
    else $error("calibration pulse without sample strobe");
  a_slow_cause: assert property ($rose(slow_pulse_out_1 | slow_pulse_out_2) |-> $past(sample_valid))
    else $error("slow pulse without sample strobe");
  a_rst_quiet: assert property (disable iff (1'b0) sys_rst |-> !(calibration_pulse_out | slow_pulse_out_1 | slow_pulse_out_2))
    else $error("pulse during reset");
  a_rst_flag: assert property (disable iff (1'b0) sys_rst |-> !negative_total_power_flag)
    else $error("flag high during reset");
  cover property ($rose(negative_total_power_flag));
  cover property ($rose(slow_pulse_out_2));
  cover property ($rose(calibration_pulse_out));
endmodule // eas_chk
bind eas_top eas_chk chk_u (.mclk, .sys_rst, .sample_valid, .slow_pulse_out_1,
  .slow_pulse_out_2, .calibration_pulse_out, .negative_total_power_flag);

//--- eas_host.sv
// host model counting meter pulses over a window
// assumes clr held high through each meter reset
`timescale 1ns/1ps
module eas_host (
  // clock and window clear
  input wire mclk,
  input wire clr,
  // meter pulses: cal, slow 1, slow 2
  input wire [2:0] p,
  // rising edge counts
  output reg [15:0] n_cal_reg,
  output reg [15:0] n_s1_reg,
  output reg [15:0] n_s2_reg
);
  reg [2:0] last_reg;
  wire [2:0] up = p & ~last_reg;
  // whole-window counts, since single intervals carry ripple
  always @(posedge mclk) begin
    last_reg <= p;
    n_cal_reg <= clr ? 16'h0000 : n_cal_reg + up[2];
    n_s1_reg <= clr ? 16'h0000 : n_s1_reg + up[1];
    n_s2_reg <= clr ? 16'h0000 : n_s2_reg + up[0];
  end
endmodule // eas_host

//--- eas_top_test.sv
// self-checking bench for eas_top with a pulse counting host
// assumes eas_top, eas_chk and eas_host compiled before it
`timescale 1ns/1ps
module eas_top_test;
  reg mclk = 1'b0;
  reg sys_rst = 1'b0;
  reg sv = 1'b1;
  reg clr = 1'b1;
  reg mode = 1'b1;
  reg [2:0] neg = 3'h0;
  reg [2:0] ph_reg = 3'h0;
  reg [15:0] keep = 16'h0000;
  wire s1, s2, cal, flag;
  wire [15:0] n_cal, n_s1, n_s2;
  // eight-sample square wave: slow enough for the current hpf
  wire [15:0] sq = ph_reg[2] ? 16'h1000 : 16'hF000;
  integer n_fail = 0;
  integer total_checks = 0;
  always #5 mclk = ~mclk;
  always @(negedge mclk) ph_reg <= ph_reg + 3'h1;
  eas_top #(.SLOW_THRESH(48'h0000_0400_0000), .PULSE_CYC(2)) dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .sample_valid(sv),
    .volt_a(sq), .curr_a(neg[0] ? 16'h0000 - sq : sq),
    .volt_b(sq), .curr_b(neg[1] ? 16'h0000 - sq : sq),
    .volt_c(sq), .curr_c(neg[2] ? 16'h0000 - sq : sq),
    .magnitude_sum_select_n(mode), .slow_pulse_out_1(s1),
    .slow_pulse_out_2(s2), .calibration_pulse_out(cal),
    .negative_total_power_flag(flag));
  eas_host host_u (.mclk(mclk), .clr(clr), .p({cal, s1, s2}),
    .n_cal_reg(n_cal), .n_s1_reg(n_s1), .n_s2_reg(n_s2));
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
    end
  endtask
  // window must stay short: lpf output ramps, cf must not saturate
  task run(input m, input [2:0] n);
    begin
      @(negedge mclk);
      sys_rst = 1'b1;
      clr = 1'b1;
      mode = m;
      neg = n;
      repeat (5) @(negedge mclk);
      sys_rst = 1'b0;
      clr = 1'b0;
      repeat (3000) @(negedge mclk);
    end
  endtask
  task t_pos;
    begin
      run(1'b1, 3'h0);
      chk("cal_faster", n_cal > n_s1 + n_s2, 1'b1);
      chk("slow_seen", n_s1 != 16'h0000, 1'b1);
      chk("alternate", n_s1 - n_s2 <= 16'h0001, 1'b1);
      chk("flag_pos", flag, 1'b0);
      sys_rst = 1'b1;
      @(negedge mclk);
      chk("rst_quiet", {s1, s2, cal, flag}, 4'h0);
      $display("test positive done");
    end
  endtask
  task t_abs_neg;
    begin
      run(1'b0, 3'h7);
      chk("abs_pulses", n_s1 != 16'h0000, 1'b1);
      chk("flag_neg", flag, 1'b1);
      $display("test absolute negative done");
    end
  endtask
  task t_arith_neg;
    begin
      run(1'b1, 3'h7);
      chk("arith_rev", n_s1 != 16'h0000, 1'b1);
      chk("cal_rev", n_cal > n_s1 + n_s2, 1'b1);
      chk("flag_rev", flag, 1'b1);
      $display("test arithmetic negative done");
    end
  endtask
  task t_mixed;
    begin
      run(1'b1, 3'h1);
      keep = n_s1 + n_s2;
      chk("mix_flag", flag, 1'b0);
      run(1'b0, 3'h1);
      chk("abs_more", n_s1 + n_s2 > keep, 1'b1);
      $display("test mixed done");
    end
  endtask
  task t_hold;
    begin
      sv = 1'b0;
      run(1'b1, 3'h0);
      chk("hold_quiet", n_cal + n_s1 + n_s2, 16'h0000);
      chk("hold_flag", flag, 1'b0);
      sv = 1'b1;
      $display("test strobe hold done");
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  initial begin
    t_pos;
    t_abs_neg;
    t_arith_neg;
    t_mixed;
    t_hold;
    summarize;
  end
endmodule // eas_top_test
